//--- logic/ddcd_pkg.sv
package ddcd_pkg;

  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SYNC = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LINK_BIT = 3;
  localparam int SYNC_ARM_BIT  = 0;
  localparam logic [2:0] CTRL_MODE_RST = 3'h0;
  localparam logic       CTRL_LINK_RST = 1'h0;

  // ==========================================================
  // Widths and buffer sizing
  localparam int W          = 16;
  localparam int OUT_W      = 15;
  localparam int REAL_W     = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_SLACK = 10;

  typedef enum logic [2:0] {
    DDCD_BYPASS = 3'b000,
    DDCD_DEC4   = 3'b001,
    DDCD_DEC8   = 3'b010,
    DDCD_DEC16  = 3'b011,
    DDCD_DEC32  = 3'b100
  } ddcd_mode_t;

  // ==========================================================
  // Half-band stages: half taps up to the center, center, shift
  localparam int HB1_H = 3;
  localparam int HB1_HALF [HB1_H] = '{-1, 0, 9};
  localparam int HB1_CTR   = 16;
  localparam int HB1_SHIFT = 5;

  localparam int HB2_H = 3;
  localparam int HB2_HALF [HB2_H] = '{-65, 0, 577};
  localparam int HB2_CTR   = 1024;
  localparam int HB2_SHIFT = 11;

  localparam int HB3_H = 5;
  localparam int HB3_HALF [HB3_H] = '{109, 0, -837, 0, 4824};
  localparam int HB3_CTR   = 8192;
  localparam int HB3_SHIFT = 14;

  localparam int HB4_H = 7;
  localparam int HB4_HALF [HB4_H] = '{-327, 0, 2231, 0, -8881, 0, 39742};
  localparam int HB4_CTR   = 65536;
  localparam int HB4_SHIFT = 17;

  localparam int HB5_H = 27;
  localparam int HB5_HALF [HB5_H] = '{-37, 0, 118, 0, -291, 0, 612, 0, -1159, 0,
                                      2031, 0, -3356, 0, 5308, 0, -8140, 0,
                                      12284, 0, -18628, 0, 29455, 0, -53191, 0,
                                      166059};
  localparam int HB5_CTR   = 262144;
  localparam int HB5_SHIFT = 19;

endpackage

//--- logic/ddcd_stream_if.sv
`timescale 1ns/1ns
interface ddcd_stream_if #(parameter int W = 16);
  logic                valid;
  logic signed [W-1:0] i;
  logic signed [W-1:0] q;
  modport src (output valid, output i, output q);
  modport snk (input valid, input i, input q);
endinterface

//--- logic/ddcd_halfband.sv
`timescale 1ns/1ns
module ddcd_halfband #(
  parameter int H          = 3,
  parameter int HALF [H]   = '{-1, 0, 9},
  parameter int CENTER     = 16,
  parameter int SHIFT      = 5,
  parameter int W          = 16
) (
  input  wire logic  pclk,    // Device clock
  input  wire logic  presetn, // Async reset
  input  wire logic  en,      // Stage in use, else pass-through
  ddcd_stream_if.snk din,     // Samples in
  ddcd_stream_if.src dout     // Samples out, half rate
);
  localparam int N  = 2 * H + 1;
  localparam int AW = 48;
  localparam logic signed [AW-1:0] RND  = AW'(1) <<< (SHIFT - 1);
  localparam logic signed [AW-1:0] VMAX = (AW'(1) <<< (W - 1)) - AW'(1);
  localparam logic signed [AW-1:0] VMIN = -(AW'(1) <<< (W - 1));

  logic signed [W-1:0]  tap    [2][N];
  logic signed [AW-1:0] prod   [2][N];
  logic signed [AW-1:0] acc    [2];
  logic signed [AW-1:0] rnd    [2];
  logic signed [W-1:0]  sat    [2];
  logic signed [W-1:0]  sample [2];
  logic                 phase;
  logic                 calc;

  assign sample[0] = din.i;
  assign sample[1] = din.q;

  // ==========================================================
  // Symmetric delay line, one product per tap
  for (genvar c = 0; c < 2; c++) begin : g_comp
    for (genvar k = 0; k < N; k++) begin : g_tap
      localparam int M    = (k < H) ? k : ((k == H) ? 0 : N - 1 - k);
      localparam int COEF = (k == H) ? CENTER : HALF[M];
      if (k == 0) begin : g_head
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) tap[c][k] <= '0;
          else if (din.valid) tap[c][k] <= sample[c];
        end
      end else begin : g_body
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) tap[c][k] <= '0;
          else if (din.valid) tap[c][k] <= tap[c][k-1];
        end
      end
      assign prod[c][k] = AW'(tap[c][k]) * AW'(COEF);
    end
    // Round half up, then clamp so nothing wraps downstream
    assign rnd[c] = (acc[c] + RND) >>> SHIFT;
    assign sat[c] = (rnd[c] > VMAX) ? W'(VMAX) :
                    (rnd[c] < VMIN) ? W'(VMIN) : W'(rnd[c]);
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      acc[c] = '0;
      for (int k = 0; k < N; k++) acc[c] = acc[c] + prod[c][k];
    end
  end

  // ==========================================================
  // Keep every second sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase      <= 1'b0;
      calc       <= 1'b0;
      dout.valid <= 1'b0;
      dout.i     <= '0;
      dout.q     <= '0;
    end else if (!en) begin
      phase      <= 1'b0;
      calc       <= 1'b0;
      dout.valid <= din.valid;
      dout.i     <= din.i;
      dout.q     <= din.q;
    end else begin
      calc       <= din.valid && phase;
      if (din.valid) phase <= !phase;
      dout.valid <= calc;
      if (calc) begin
        dout.i <= sat[0];
        dout.q <= sat[1];
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  decim_half_a: assert property (en && din.valid && !phase |=> !calc)
    else $error("stage fired on an even input");
  calc_out_a: assert property ((en && calc) ##1 en |-> dout.valid)
    else $error("stage result not presented");
  sat_high_a: assert property ((en && calc && rnd[0] > VMAX) ##1 en |-> dout.i == W'(VMAX))
    else $error("positive overflow not clamped");
endmodule // ddcd_halfband

//--- logic/ddcd_fifo.sv
`timescale 1ns/1ns
module ddcd_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       pclk,      // Device clock
  input  wire logic                       presetn,   // Async reset
  input  wire logic                       in_valid,  // Push request
  output wire logic                       in_ready,  // Not full
  input  wire logic [W-1:0]               in_data,   // Push word
  output wire logic                       out_valid, // Not empty
  input  wire logic                       out_ready, // Pop request
  output wire logic [W-1:0]               out_data,  // Head word
  output wire logic [$clog2(DEPTH):0]     level      // Words held
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  wire [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

  assign in_ready  = count != FULL;
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  for (genvar e = 0; e < DEPTH; e++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mem[e] <= '0;
      else if (push && wr_ptr == AW'(e)) mem[e] <= in_data;
    end
  end

  // Depth is a power of two, so pointers wrap by themselves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= next_count;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  fill_full_a: assert property (push && !pop && count == FULL - 1 |=> !in_ready)
    else $error("fifo not full after last push");
  drain_empty_a: assert property (pop && !push && count == 1 |=> !out_valid)
    else $error("fifo not empty after last pop");
endmodule // ddcd_fifo

//--- logic/ddcd_decim_chain.sv
// Operation
// - Armed device resyncs NCO accumulators on next SYSREF rising edge.
// - Stages work on complex I/Q; output is 15 bits per component.
// - Every stage is a linear-phase FIR filter.
// - Bypass skips decimation and sends real 12-bit samples at full rate.
// - Factor D gives one complex sample per D input samples.
// - Factor picks trailing stages: 4 uses last two, 32 uses all five.
// - Each stage halves rate with a mirrored symmetric tap set.
// - First and second stage tap sets with scales 2^-5 and 2^-11.
// - Final stage 55-tap set, center 262144, scale 2^-19.
// - Decimating modes keep 0.8 band, over 90 dB stop, 0.001 dB ripple.
// - Output words: 15 data bits high, overrange flag in bit zero.
// - Link mode field selects decimation factor or bypass.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module ddcd_decim_chain
  import ddcd_pkg::*;
(
  input  wire logic                       pclk,                // Device clock
  input  wire logic                       presetn,             // Async reset, low
  input  wire logic                       psel,                // APB select
  input  wire logic                       penable,             // APB enable
  input  wire logic                       pwrite,              // APB write
  input  wire logic [11:0]                paddr,               // APB byte address
  input  wire logic [31:0]                pwdata,              // APB write data
  output logic      [31:0]                prdata,              // APB read data
  output logic                            pready,              // APB ready
  output logic                            pslverr,             // Unmapped address
  input  wire logic                       in_valid,            // Mixer sample valid
  output logic                            in_ready,            // Room for a sample
  input  wire logic [ddcd_pkg::W-1:0]     in_i,                // Mixer in-phase
  input  wire logic [ddcd_pkg::W-1:0]     in_q,                // Mixer quadrature
  input  wire logic [ddcd_pkg::REAL_W-1:0] in_real,            // Real sample, bypass
  input  wire logic                       overrange_flag_low,  // Threshold 0 hit
  input  wire logic                       overrange_flag_high, // Threshold 1 hit
  input  wire logic                       sysref,              // SYSREF level
  output logic                            out_valid,           // Output word valid
  input  wire logic                       out_ready,           // Link takes word
  output logic      [15:0]                out_i_word,          // I word or real
  output logic      [15:0]                out_q_word,          // Q word
  output logic                            serial_link_enable,  // Link enable bit
  output logic                            nco_resync           // NCO phase reset pulse
);
  import ddcd_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] READY_LIMIT = LW'(FIFO_DEPTH - FIFO_SLACK);

  // ==========================================================
  // Register state
  logic [2:0] mode_q;
  logic       nco_sync_arm_on_sysref;
  logic [7:0] sync_cnt;
  logic       sysref_q;

  // ==========================================================
  // APB decode
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_sync = paddr == ADDR_SYNC;
  wire hit_stat = paddr == ADDR_STAT;
  wire addr_hit = hit_ctrl || hit_sync || hit_stat;
  wire wr_ctrl  = access && pwrite && hit_ctrl;
  wire wr_arm   = access && pwrite && hit_sync && pwdata[SYNC_ARM_BIT];

  wire [LW-1:0] fifo_level;
  wire [31:0] rd_ctrl = {28'h0, serial_link_enable, mode_q};
  wire [31:0] rd_sync = {16'h0, sync_cnt, 7'h0, nco_sync_arm_on_sysref};
  wire [31:0] rd_stat = {22'h0, in_ready, 4'h0, fifo_level};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_sync ? rd_sync :
                        hit_stat ? rd_stat : 32'h0;

  // Zero wait state: ready rises in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addr_hit;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q             <= CTRL_MODE_RST;
      serial_link_enable <= CTRL_LINK_RST;
    end else if (wr_ctrl) begin
      mode_q             <= pwdata[CTRL_MODE_LSB +: 3];
      serial_link_enable <= pwdata[CTRL_LINK_BIT];
    end
  end

  // ==========================================================
  // NCO sync arming against free-running SYSREF
  wire sysref_rise = sysref && !sysref_q;
  wire fire        = nco_sync_arm_on_sysref && sysref_rise;
  // A write in the same cycle as an edge arms for the next edge
  wire next_armed  = wr_arm ? 1'b1 : (fire ? 1'b0 : nco_sync_arm_on_sysref);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_q               <= 1'b0;
      nco_sync_arm_on_sysref <= 1'b0;
      nco_resync             <= 1'b0;
      sync_cnt               <= 8'h00;
    end else begin
      sysref_q               <= sysref;
      nco_sync_arm_on_sysref <= next_armed;
      nco_resync             <= fire;
      if (fire) sync_cnt <= sync_cnt + 8'h01;
    end
  end

  // ==========================================================
  // Mode to stage enables
  wire decim = (mode_q >= DDCD_DEC4) && (mode_q <= DDCD_DEC32);
  wire [4:0] stage_en;
  for (genvar s = 0; s < 5; s++) begin : g_en
    // Shorter factors drop the early, high-rate stages
    assign stage_en[s] = decim && (3'(4 - s) <= mode_q);
  end

  // ==========================================================
  // Input capture
  ddcd_stream_if #(.W(W)) st [6] ();
  logic                cap_valid;
  logic signed [W-1:0] cap_i;
  logic signed [W-1:0] cap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_valid <= 1'b0;
      cap_i     <= '0;
      cap_q     <= '0;
    end else begin
      cap_valid <= in_valid && in_ready;
      if (in_valid && in_ready) begin
        cap_i <= decim ? in_i : {in_real, 4'h0};
        cap_q <= decim ? in_q : '0;
      end
    end
  end

  assign st[0].valid = cap_valid;
  assign st[0].i     = cap_i;
  assign st[0].q     = cap_q;

  // ==========================================================
  // Cascade of half-band stages
  ddcd_halfband #(
    .H      (HB1_H),
    .HALF   (HB1_HALF),
    .CENTER (HB1_CTR),
    .SHIFT  (HB1_SHIFT),
    .W      (W)
  ) u_halfband_stage_first (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (stage_en[0]),
    .din     (st[0]),
    .dout    (st[1])
  );

  ddcd_halfband #(
    .H      (HB2_H),
    .HALF   (HB2_HALF),
    .CENTER (HB2_CTR),
    .SHIFT  (HB2_SHIFT),
    .W      (W)
  ) u_halfband_stage_second (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (stage_en[1]),
    .din     (st[1]),
    .dout    (st[2])
  );

  ddcd_halfband #(
    .H      (HB3_H),
    .HALF   (HB3_HALF),
    .CENTER (HB3_CTR),
    .SHIFT  (HB3_SHIFT),
    .W      (W)
  ) u_halfband_stage_third (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (stage_en[2]),
    .din     (st[2]),
    .dout    (st[3])
  );

  ddcd_halfband #(
    .H      (HB4_H),
    .HALF   (HB4_HALF),
    .CENTER (HB4_CTR),
    .SHIFT  (HB4_SHIFT),
    .W      (W)
  ) u_halfband_stage_fourth (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (stage_en[3]),
    .din     (st[3]),
    .dout    (st[4])
  );

  // Long equiripple stage carries the 90 dB stop band and tight ripple
  ddcd_halfband #(
    .H      (HB5_H),
    .HALF   (HB5_HALF),
    .CENTER (HB5_CTR),
    .SHIFT  (HB5_SHIFT),
    .W      (W)
  ) u_halfband_stage_final (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (stage_en[4]),
    .din     (st[4]),
    .dout    (st[5])
  );

  // ==========================================================
  // Output word format
  function automatic logic [OUT_W-1:0] ddcd_to15(input logic signed [W-1:0] x);
    logic signed [W:0] r;
    r = ((W + 1)'(x) + (W + 1)'(1)) >>> 1;
    return (r > (W + 1)'(16'sh3FFF)) ? 15'h3FFF : r[OUT_W-1:0];
  endfunction

  wire [15:0] fmt_i = decim ? {ddcd_to15(st[5].i), overrange_flag_low}
                            : st[5].i;
  wire [15:0] fmt_q = decim ? {ddcd_to15(st[5].q), overrange_flag_high}
                            : 16'h0000;

  // ==========================================================
  // Buffer toward the link
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire        fifo_take = !out_valid || out_ready;

  ddcd_fifo #(
    .W     (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (st[5].valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({fmt_i, fmt_q}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Slack covers samples already inside the cascade when ready drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
      out_i_word <= 16'h0000;
      out_q_word <= 16'h0000;
    end else begin
      in_ready <= fifo_level < READY_LIMIT;
      if (fifo_take) begin
        out_valid <= fifo_out_valid;
        if (fifo_out_valid) {out_i_word, out_q_word} <= fifo_out_data;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  arm_fire_a: assert property (fire && !wr_arm |=> nco_resync && !nco_sync_arm_on_sysref)
    else $error("armed sync did not fire on SYSREF edge");
  quiet_unarmed_a: assert property (!nco_sync_arm_on_sysref |=> !nco_resync)
    else $error("NCO resync without arming");
  arm_wins_a: assert property (wr_arm |=> nco_sync_arm_on_sysref)
    else $error("arming write lost");
  bypass_rate_a: assert property (!decim && cap_valid ##1 !decim [*5] |-> st[5].valid)
    else $error("bypass sample not passed at full rate");
  dec8_stages_a: assert property (mode_q == DDCD_DEC8 |-> stage_en == 5'b11100)
    else $error("wrong stages for factor eight");
  no_loss_a: assert property (st[5].valid |-> fifo_in_ready)
    else $error("chain output dropped on full buffer");
  apb_ready_a: assert property (setup |=> pready && !setup)
    else $error("APB access not answered in one cycle");
  ready_gate_a: assert property (fifo_level >= READY_LIMIT |=> !in_ready)
    else $error("input accepted without buffer slack");
endmodule // ddcd_decim_chain

//--- verif/ddcd_link_sink.sv
`timescale 1ns/1ns
// ==========================================
// Serial link side: takes words, may stall
module ddcd_link_sink (
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Reset
  input  wire logic        stall,      // Refuse words
  input  wire logic        slow,       // Ready every other cycle
  input  wire logic        clr,        // Clear count
  input  wire logic        out_valid,  // Word offered
  output logic             out_ready,  // Taking words
  input  wire logic [15:0] out_i_word, // I word
  input  wire logic [15:0] out_q_word, // Q word
  output int               words,      // Words taken
  output logic [15:0]      last_i,     // Last I
  output logic [15:0]      last_q      // Last Q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
      words <= 0;
      last_i <= 16'h0000;
      last_q <= 16'h0000;
    end else begin
      out_ready <= !stall && (!slow || !out_ready);
      if (clr) begin
        words <= 0;
      end else if (out_valid && out_ready) begin
        words <= words + 1;
        last_i <= out_i_word;
        last_q <= out_q_word;
      end
    end
  end
endmodule // ddcd_link_sink

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import ddcd_pkg::*;
  typedef struct {ddcd_mode_t m; int n; int w; logic [15:0] ei; logic [15:0] eq;} ddcd_row_t;
  logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, sysref = 0;
  logic overrange_flag_low = 0, overrange_flag_high = 1, stall = 0, slow = 0, clr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, in_ready, out_valid, out_ready, serial_link_enable, nco_resync, er;
  logic [W-1:0] in_i = 16'h0000, in_q = 16'h0000;
  logic [REAL_W-1:0] in_real = 12'hA5C;
  logic [15:0] out_i_word, out_q_word, last_i, last_q;
  int words, num_errors = 0, compares = 0, cyc = 0, pulses = 0, k, t;
  // Zero input so decimated words show only the flag bits
  // Decimating rows first: stages keep old taps across mode changes
  ddcd_row_t rows [5] = '{'{DDCD_DEC4, 32, 8, 16'h0000, 16'h0001},
    '{DDCD_DEC8, 64, 8, 16'h0000, 16'h0001}, '{DDCD_DEC16, 128, 8, 16'h0000, 16'h0001},
    '{DDCD_DEC32, 256, 8, 16'h0000, 16'h0001}, '{DDCD_BYPASS, 8, 8, 16'hA5C0, 16'h0000}};

  ddcd_decim_chain dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_valid, .in_ready, .in_i, .in_q, .in_real, .overrange_flag_low,
    .overrange_flag_high, .sysref, .out_valid, .out_ready, .out_i_word, .out_q_word,
    .serial_link_enable, .nco_resync);
  ddcd_link_sink sink (.pclk, .presetn, .stall, .slow, .clr, .out_valid, .out_ready,
    .out_i_word, .out_q_word, .words, .last_i, .last_q);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (nco_resync === 1'b1) pulses++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Called just after a rising edge; waits for pready, no fixed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  // Offers up to n samples; with stop set, quits once in_ready falls
  task automatic feed(input int n, input logic stop, output int acc);
    int w;
    acc = 0;
    w = 0;
    in_valid <= 1'b1;
    while (acc < n && !(stop && w > 0 && in_ready === 1'b0)) begin
      @(posedge pclk);
      w++;
      if (in_ready === 1'b1) acc++;
    end
    in_valid <= 1'b0;
  endtask
  task automatic wait_words(input int n);
    for (t = 0; t < 400 && words < n; t++) @(posedge pclk);
    repeat (40) @(posedge pclk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset out_valid", out_valid, 0);
    apb(0, ADDR_CTRL, 0, rd, er);
    chk("ctrl reset", rd, {CTRL_LINK_RST, CTRL_MODE_RST});
    apb(0, 12'h00C, 0, rd, er);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    foreach (rows[r]) begin
      apb(1, ADDR_CTRL, 32'h8 | 32'(rows[r].m), rd, er);
      clr <= 1'b1;
      slow <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      chk("link enable", serial_link_enable, 1);
      feed(rows[r].n, 0, k);
      wait_words(rows[r].w);
      chk("word count", words, rows[r].w);
      chk("i word", last_i, rows[r].ei);
      chk("q word", last_q, rows[r].eq);
    end
    // Unarmed rise must not touch the accumulators
    slow <= 1'b0;
    sysref <= 1'b1;
    repeat (3) @(posedge pclk);
    sysref <= 1'b0;
    apb(1, ADDR_SYNC, 1, rd, er);
    apb(0, ADDR_SYNC, 0, rd, er);
    chk("armed", rd[0], 1);
    chk("no early pulse", pulses, 0);
    sysref <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("resync pulse", pulses, 1);
    sysref <= 1'b0;
    repeat (2) @(posedge pclk);
    sysref <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("single pulse", pulses, 1);
    apb(0, ADDR_SYNC, 0, rd, er);
    chk("arm cleared", rd[0], 0);
    // Buffer: fill against a stalled link, then drain with no loss
    apb(1, ADDR_CTRL, 32'h8, rd, er);
    stall <= 1'b1;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    feed(100, 1, k);
    chk("backpressure", k < 100, 1);
    repeat (12) @(posedge pclk);
    apb(0, ADDR_STAT, 0, rd, er);
    // One word already waits in the output register
    chk("fifo level", rd[4:0], 5'(k - 1));
    stall <= 1'b0;
    wait_words(k);
    chk("drained words", words, k);
    apb(0, ADDR_STAT, 0, rd, er);
    chk("fifo empty", rd[4:0], 0);
    finish_test();
  end
endmodule // testbench
